/* File: hdl/ssc_pkg.sv */
package ssc_pkg;
	// register byte offsets
	localparam logic [7:0] ADDR_GPIO0 = 8'h0D;
	localparam logic [7:0] ADDR_GPIO21 = 8'h0E;
	localparam logic [7:0] ADDR_GPO4_IO3 = 8'h0F;
	localparam logic [7:0] ADDR_GPO65 = 8'h10;
	localparam logic [7:0] ADDR_GPO87 = 8'h11;
	localparam logic [7:0] ADDR_DPATH = 8'h12;
	localparam logic [7:0] ADDR_SBCTL = 8'h13;
	localparam logic [7:0] ADDR_CRCCNT = 8'h14;
	localparam logic [7:0] ADDR_STAT = 8'h15;
	localparam logic [7:0] ADDR_INTCTL = 8'hC6;
	localparam logic [7:0] ADDR_ISR = 8'hC7;
	// field positions
	localparam int INTCTL_OUT_EN = 5;
	localparam int INTCTL_FWD = 0;
	localparam int DPATH_CHB = 0;
	localparam int DPATH_18BIT = 2;
	localparam int SB_PATTERN = 0;
	localparam int SB_OSC25 = 1;
	localparam int SB_LOWFREQ = 2;
	localparam int SB_COMPAT = 3;
	localparam int SB_RISING = 4;
	localparam int SB_AUD_BLANK = 5;
	localparam int SB_OSC_FB = 6;
	// nibble codes
	localparam logic [3:0] NIB_FWD = 4'h3;
	localparam logic [3:0] NIB_BC = 4'h5;
	localparam logic [3:0] NIB_ONE = 4'h9;
	localparam logic [3:0] NIB_ZERO = 4'h1;
	// reset values
	localparam logic [7:0] RST_CFG = 8'h00;
	localparam logic [7:0] RST_SBCTL = 8'h10;
	localparam logic [12:0] RST_SYNC = 13'h0002;
	// async input vector bit positions
	localparam int AI_PCLK = 0;
	localparam int AI_RINT = 1;
	localparam int AI_COL = 2;
	localparam int AI_AUD = 6;
	localparam int AI_DE = 10;
	localparam int AI_PD = 11;
	localparam int AI_STRAP = 12;
	// timing
	localparam int CLK_NS = 50;
	localparam int PCLK_LOSS_NS = 1000;
	localparam int PCLK_LOSS_CYC = PCLK_LOSS_NS / CLK_NS;
	localparam logic [4:0] LOSS_CNT_MAX = 5'(PCLK_LOSS_CYC);
	localparam int OSC_TICK_NS = 100;
	localparam logic [1:0] OSC_TICK_MAX = 2'((OSC_TICK_NS + CLK_NS - 1) / CLK_NS - 1);
	localparam logic [2:0] STRAP_CAP_CYC = 3'h4;
	localparam logic [7:0] CRC_CNT_MAX = 8'hFF;

	typedef enum logic [1:0] {OSC_33, OSC_25, OSC_12P5} ssc_osc_e;
	typedef enum logic {BIST_OFF, BIST_RUN} ssc_bist_e;
endpackage

/* File: hdl/ssc_sideband_control.sv */
// Design decision made here: strobed register access.
`timescale 1ns/100ps
// Overview of operation
// - Remote interrupt input going low drives local interrupt output low.
// - Reading interrupt status clears pending interrupt and releases the output.
// - A new interrupt needs a fresh falling edge after the last clear.
// - Pattern is sent when powered and enabled, even without parallel input.
// - Without pixel clock the pattern may run from the internal oscillator.
// - In 18-bit mode four low colour pins become forward or back-channel lines.
// - 18-bit mode is selected by writing 0x04 to the data path register.
// - Nibble 3 selects forward input, 5 back-channel output, per line.
// - Five register-driven outputs are outputs only, set by local bits.
// - Output nibble 9 drives one, nibble 1 drives zero.
// - 24-bit mode carries three audio signals in blanking or active video.
// - Secondary audio channel enabled by strap pin or data path bit 0.
// - Audio path accepts 32 to 192 kHz samples, bit clock to 12.288 MHz.
// - Self-test is refused in backward compatible mode.
// - Self-test request from back channel sends pattern at full link speed.
// - Self-test runs from pixel clock or oscillator at 33, 25 or 12.5 MHz.
// - In self-test the colour inputs are ignored and an all-zero payload sent.
// - Back-channel CRC errors counted in 8 bits, cleared on self-test entry.
module ssc_sideband_control (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic pclk,
	input wire logic power_down,
	input wire logic chan_b_strap,
	input wire logic remote_interrupt_in_n,
	output logic interrupt_out_n,
	input wire logic [3:0] color_low_in,
	output logic [3:0] color_low_out,
	output logic [3:0] color_low_oe,
	input wire logic [3:0] bc_gpio,
	output logic [3:0] fwd_gpio,
	output logic [8:4] register_driven_output,
	input wire logic aud_clk,
	input wire logic aud_ws,
	input wire logic aud_da,
	input wire logic secondary_audio_data,
	input wire logic video_de,
	output logic [3:0] fwd_aud,
	output logic fwd_aud_valid,
	output logic frame_strobe,
	output logic pattern_active,
	output logic zero_payload,
	output logic link_enable,
	output logic use_oscillator,
	output ssc_pkg::ssc_osc_e osc_select,
	input wire logic selftest_req,
	input wire logic link_detect,
	input wire logic bc_crc_err
);
	import ssc_pkg::*;

	function automatic logic nib_is(input logic [3:0] nib, input logic [3:0] code);
		nib_is = (nib == code);
	endfunction

	logic [12:0] async_raw;
	logic [12:0] s1_q, s2_q, s3_q, filt_q, filt_d;
	logic [7:0] gpio0_q, gpio21_q, gpo43_q, gpo65_q, gpo87_q, dpath_q, sbctl_q, intctl_q;
	logic [7:0] rdata_d, reg_rdata_q, crc_cnt_q;
	logic pend_q, pend_d, rint_prev_q, int_n_q, isr_rd, rint_fall, int_arm;
	logic pclk_prev_q, sel_edge, pclk_present, osc_tick, frame_tick;
	logic [4:0] loss_cnt_q;
	logic [1:0] osc_cnt_q;
	logic [2:0] strap_cnt_q;
	logic strap_q, chb_en, mode18, bist_run, audio_slot;
	logic [3:0] fwd_mask, bc_mask, col_out_q, col_oe_q, fwd_gpio_q, fwd_aud_q;
	logic [3:0] line_nib [4];
	logic [3:0] gpo_nib [5];
	logic [8:4] gpo_q, gpo_d;
	logic frame_q, aud_valid_q, pat_q, zero_q, link_en_q, use_osc_q;
	ssc_osc_e osc_q;
	ssc_bist_e bist_q;

	// each of the 13 async inputs passes three flops; a level counts once stages two and three agree
	assign async_raw = {chan_b_strap, power_down, video_de, secondary_audio_data, aud_da,
		aud_ws, aud_clk, color_low_in, remote_interrupt_in_n, pclk};
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s1_q <= RST_SYNC;
			s2_q <= RST_SYNC;
			s3_q <= RST_SYNC;
			filt_q <= RST_SYNC;
		end else begin
			s1_q <= async_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			filt_q <= filt_d;
		end
	end
	genvar gi;
	generate
		for (gi = 0; gi < 13; gi++) begin : g_filt
			assign filt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : filt_q[gi];
		end
	endgenerate

	// strap is caught from the filter's next value; filt_q itself is still at reset then
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			strap_cnt_q <= 3'h0;
			strap_q <= 1'b0;
		end else if (strap_cnt_q != STRAP_CAP_CYC) begin
			strap_cnt_q <= strap_cnt_q + 3'h1;
			if (strap_cnt_q == STRAP_CAP_CYC - 3'h1) begin
				strap_q <= filt_d[AI_STRAP];
			end
		end
	end

	// configuration registers, written in one cycle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			gpio0_q <= RST_CFG;
			gpio21_q <= RST_CFG;
			gpo43_q <= RST_CFG;
			gpo65_q <= RST_CFG;
			gpo87_q <= RST_CFG;
			dpath_q <= RST_CFG;
			sbctl_q <= RST_SBCTL;
			intctl_q <= RST_CFG;
		end else if (reg_wr) begin
			if (reg_addr == ADDR_GPIO0) begin
				gpio0_q <= reg_wdata;
			end else if (reg_addr == ADDR_GPIO21) begin
				gpio21_q <= reg_wdata;
			end else if (reg_addr == ADDR_GPO4_IO3) begin
				gpo43_q <= reg_wdata;
			end else if (reg_addr == ADDR_GPO65) begin
				gpo65_q <= reg_wdata;
			end else if (reg_addr == ADDR_GPO87) begin
				gpo87_q <= reg_wdata;
			end else if (reg_addr == ADDR_DPATH) begin
				dpath_q <= reg_wdata;
			end else if (reg_addr == ADDR_SBCTL) begin
				sbctl_q <= reg_wdata;
			end else if (reg_addr == ADDR_INTCTL) begin
				intctl_q <= reg_wdata;
			end
		end
	end

	// read mux; unmapped offsets read zero, data stands one cycle only
	always_comb begin
		rdata_d = 8'h00;
		if (reg_addr == ADDR_GPIO0) begin
			rdata_d = gpio0_q;
		end else if (reg_addr == ADDR_GPIO21) begin
			rdata_d = gpio21_q;
		end else if (reg_addr == ADDR_GPO4_IO3) begin
			rdata_d = gpo43_q;
		end else if (reg_addr == ADDR_GPO65) begin
			rdata_d = gpo65_q;
		end else if (reg_addr == ADDR_GPO87) begin
			rdata_d = gpo87_q;
		end else if (reg_addr == ADDR_DPATH) begin
			rdata_d = dpath_q;
		end else if (reg_addr == ADDR_SBCTL) begin
			rdata_d = sbctl_q;
		end else if (reg_addr == ADDR_CRCCNT) begin
			rdata_d = crc_cnt_q;
		end else if (reg_addr == ADDR_STAT) begin
			rdata_d = {5'h00, strap_q, pclk_present, bist_run};
		end else if (reg_addr == ADDR_INTCTL) begin
			rdata_d = intctl_q;
		end else if (reg_addr == ADDR_ISR) begin
			rdata_d = {7'h00, pend_q};
		end
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			reg_rdata_q <= 8'h00;
		end else begin
			reg_rdata_q <= reg_rd ? rdata_d : 8'h00;
		end
	end
	assign reg_rdata = reg_rdata_q;

	// interrupt relay: edge-triggered so a held-low remote line cannot re-raise
	assign int_arm = intctl_q[INTCTL_OUT_EN] & intctl_q[INTCTL_FWD];
	assign rint_fall = rint_prev_q & ~filt_q[AI_RINT];
	assign isr_rd = reg_rd & (reg_addr == ADDR_ISR);
	always_comb begin
		pend_d = pend_q;
		if (rint_fall && int_arm) begin
			pend_d = 1'b1;
		end else if (isr_rd) begin
			pend_d = 1'b0;
		end
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rint_prev_q <= 1'b1;
			pend_q <= 1'b0;
			int_n_q <= 1'b1;
		end else begin
			rint_prev_q <= filt_q[AI_RINT];
			pend_q <= pend_d;
			int_n_q <= ~(pend_q & intctl_q[INTCTL_OUT_EN]);
		end
	end
	assign interrupt_out_n = int_n_q;

	// pixel clock edge pick and loss detect; below ~500 kHz counts as absent
	assign sel_edge = sbctl_q[SB_RISING] ? (filt_q[AI_PCLK] & ~pclk_prev_q)
		: (~filt_q[AI_PCLK] & pclk_prev_q);
	assign pclk_present = (loss_cnt_q != LOSS_CNT_MAX);
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pclk_prev_q <= 1'b0;
			loss_cnt_q <= LOSS_CNT_MAX;
		end else begin
			pclk_prev_q <= filt_q[AI_PCLK];
			if (filt_q[AI_PCLK] != pclk_prev_q) begin
				loss_cnt_q <= 5'h00;
			end else if (pclk_present) begin
				loss_cnt_q <= loss_cnt_q + 5'h01;
			end
		end
	end

	// oscillator stand-in tick used only while the pixel clock is missing
	assign osc_tick = (osc_cnt_q == OSC_TICK_MAX);
	assign frame_tick = use_osc_q ? osc_tick : sel_edge;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			osc_cnt_q <= 2'h0;
		end else begin
			osc_cnt_q <= osc_tick ? 2'h0 : osc_cnt_q + 2'h1;
		end
	end

	// self-test sequencing; refused while backward compatible
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			bist_q <= BIST_OFF;
		end else begin
			case (bist_q)
				BIST_OFF: begin
					if (selftest_req && !sbctl_q[SB_COMPAT]) begin
						bist_q <= BIST_RUN;
					end
				end
				BIST_RUN: begin
					if (!selftest_req || sbctl_q[SB_COMPAT]) begin
						bist_q <= BIST_OFF;
					end
				end
				default: bist_q <= BIST_OFF;
			endcase
		end
	end
	assign bist_run = (bist_q == BIST_RUN);

	// crc error count: cleared on entry, held after exit for software
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			crc_cnt_q <= 8'h00;
		end else if (!bist_run && selftest_req && !sbctl_q[SB_COMPAT]) begin
			crc_cnt_q <= 8'h00;
		end else if (bist_run && link_detect && bc_crc_err && crc_cnt_q != CRC_CNT_MAX) begin
			crc_cnt_q <= crc_cnt_q + 8'h01;
		end
	end

	// pattern, payload and clock source status toward the link logic
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pat_q <= 1'b0;
			zero_q <= 1'b0;
			link_en_q <= 1'b0;
			use_osc_q <= 1'b0;
			osc_q <= OSC_33;
		end else begin
			pat_q <= (~filt_q[AI_PD] & sbctl_q[SB_PATTERN]) | bist_run;
			zero_q <= bist_run;
			link_en_q <= ~filt_q[AI_PD] | bist_run;
			use_osc_q <= ~pclk_present & (sbctl_q[SB_OSC_FB] | bist_run);
			if (sbctl_q[SB_LOWFREQ]) begin
				osc_q <= OSC_12P5;
			end else if (sbctl_q[SB_OSC25]) begin
				osc_q <= OSC_25;
			end else begin
				osc_q <= OSC_33;
			end
		end
	end
	assign pattern_active = pat_q;
	assign zero_payload = zero_q;
	assign link_enable = link_en_q;
	assign use_oscillator = use_osc_q;
	assign osc_select = osc_q;

	// general lines: nibble picks direction per line, only in 18-bit mode
	assign mode18 = dpath_q[DPATH_18BIT];
	assign line_nib[0] = gpio0_q[3:0];
	assign line_nib[1] = gpio21_q[3:0];
	assign line_nib[2] = gpio21_q[7:4];
	assign line_nib[3] = gpo43_q[3:0];
	assign gpo_nib[0] = gpo43_q[7:4];
	assign gpo_nib[1] = gpo65_q[3:0];
	assign gpo_nib[2] = gpo65_q[7:4];
	assign gpo_nib[3] = gpo87_q[3:0];
	assign gpo_nib[4] = gpo87_q[7:4];
	generate
		for (gi = 0; gi < 4; gi++) begin : g_line
			assign fwd_mask[gi] = mode18 & nib_is(line_nib[gi], NIB_FWD);
			assign bc_mask[gi] = mode18 & nib_is(line_nib[gi], NIB_BC);
		end
		for (gi = 0; gi < 5; gi++) begin : g_gpo
			assign gpo_d[gi + 4] = nib_is(gpo_nib[gi], NIB_ONE) ? 1'b1
				: nib_is(gpo_nib[gi], NIB_ZERO) ? 1'b0 : gpo_q[gi + 4];
		end
	endgenerate
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			col_out_q <= 4'h0;
			col_oe_q <= 4'h0;
			gpo_q <= 5'h00;
		end else begin
			col_out_q <= bc_gpio & bc_mask;
			col_oe_q <= bc_mask;
			gpo_q <= gpo_d;
		end
	end
	assign color_low_out = col_out_q;
	assign color_low_oe = col_oe_q;
	assign register_driven_output = gpo_q;

	// forward frame contents; other codes leave a line idle
	assign chb_en = strap_q | dpath_q[DPATH_CHB];
	assign audio_slot = sbctl_q[SB_AUD_BLANK] ? ~filt_q[AI_DE] : filt_q[AI_DE];
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			frame_q <= 1'b0;
			fwd_gpio_q <= 4'h0;
			fwd_aud_q <= 4'h0;
			aud_valid_q <= 1'b0;
		end else begin
			frame_q <= frame_tick;
			if (frame_tick) begin
				fwd_gpio_q <= bist_run ? 4'h0 : filt_q[AI_COL +: 4] & fwd_mask;
				fwd_aud_q <= {filt_q[AI_AUD + 3] & chb_en, filt_q[AI_AUD +: 3]};
				aud_valid_q <= audio_slot & ~bist_run;
			end
		end
	end
	assign frame_strobe = frame_q;
	assign fwd_gpio = fwd_gpio_q;
	assign fwd_aud = fwd_aud_q;
	assign fwd_aud_valid = aud_valid_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_fall_armed;
		rint_fall && int_arm;
	endsequence
	sequence s_bist_enter;
		!bist_run && selftest_req && !sbctl_q[SB_COMPAT] ##1 bist_run;
	endsequence

	a_int_drive_low: assert property (s_fall_armed |-> ##2 !interrupt_out_n)
		else $error("interrupt output not driven low after remote fall");
	a_isr_read_release: assert property (isr_rd && !(rint_fall && int_arm)
		|=> !pend_q ##1 interrupt_out_n)
		else $error("status read did not release interrupt");
	a_int_edge_only: assert property ($rose(pend_q) |-> $past(rint_fall))
		else $error("interrupt raised without a remote falling edge");
	a_pattern_sent: assert property (!filt_q[AI_PD] && sbctl_q[SB_PATTERN]
		|=> pattern_active)
		else $error("pattern not active while enabled and powered");
	a_osc_fallback: assert property (!pclk_present && sbctl_q[SB_OSC_FB]
		|=> use_oscillator)
		else $error("oscillator not used without pixel clock");
	a_gpio_bc_drive: assert property (bc_mask[0] |=> color_low_oe[0]
		&& color_low_out[0] == $past(bc_gpio[0]))
		else $error("back-channel line 0 not driven");
	a_gpo_one: assert property (reg_wr && reg_addr == ADDR_GPO87 && reg_wdata == 8'h91
		|-> ##2 register_driven_output[8] && !register_driven_output[7])
		else $error("register output 8 level wrong");
	a_bist_compat: assert property (sbctl_q[SB_COMPAT] |=> !bist_run)
		else $error("self-test running in compatible mode");
	a_bist_clear: assert property (s_bist_enter |-> crc_cnt_q == 8'h00)
		else $error("crc count not cleared on self-test entry");
	a_zero_frame: assert property (bist_run && frame_tick |=> fwd_gpio == 4'h0
		&& zero_payload)
		else $error("self-test frame not all zero");
	a_fwd_sample: assert property (sel_edge && !use_osc_q && !bist_run
		|=> frame_strobe && fwd_gpio == ($past(filt_q[AI_COL +: 4]) & $past(fwd_mask)))
		else $error("forward inputs not taken on selected edge");
endmodule // ssc_sideband_control

/* File: bench/ssc_deser_model.sv */
`timescale 1ns/100ps
// far-end deserializer: back-channel levels, self-test request, crc flag and pass flag
module ssc_deser_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic frame_strobe,
	input wire logic bist_cmd,
	input wire logic err_cmd,
	input wire logic int_cmd,
	input wire logic [3:0] bc_level,
	output logic [3:0] bc_gpio,
	output logic selftest_req,
	output logic link_detect,
	output logic bc_crc_err,
	output logic remote_interrupt_in_n,
	output logic pass_out
);
	logic seen_q;
	// back channel follows the bench's commands one cycle late, like a real link
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			bc_gpio <= 4'h0;
			selftest_req <= 1'b0;
			link_detect <= 1'b0;
			remote_interrupt_in_n <= 1'b1;
		end else begin
			bc_gpio <= bc_level;
			selftest_req <= bist_cmd;
			link_detect <= bist_cmd;
			remote_interrupt_in_n <= ~int_cmd;
		end
	end
	// errored frames pulse crc and toggle pass; the verdict is held once the run ends
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			bc_crc_err <= 1'b0;
			pass_out <= 1'b0;
			seen_q <= 1'b0;
		end else begin
			bc_crc_err <= selftest_req & err_cmd & frame_strobe;
			if (bist_cmd & ~selftest_req) begin
				pass_out <= 1'b1;
				seen_q <= 1'b0;
			end else if (selftest_req & err_cmd & frame_strobe) begin
				pass_out <= ~pass_out;
				seen_q <= 1'b1;
			end else if (~bist_cmd & selftest_req) begin
				pass_out <= ~seen_q;
			end
		end
	end
endmodule // ssc_deser_model

/* File: bench/ssc_sideband_control_test.sv */
`timescale 1ns/100ps
module ssc_sideband_control_test;
	import ssc_pkg::*;
	logic clk, reset, reg_wr, reg_rd, pclk, pclk_on, power_down, video_de, strap;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	logic interrupt_out_n, frame_strobe, pattern_active, zero_payload, link_enable, use_oscillator;
	logic remote_interrupt_in_n, selftest_req, link_detect, bc_crc_err, pass_out;
	logic bist_cmd, err_cmd, int_cmd, fwd_aud_valid, aud_clk, aud_ws, aud_da, aud_db;
	logic [3:0] color_low_in, color_low_out, color_low_oe, bc_gpio, fwd_gpio, fwd_aud, bc_level;
	logic [8:4] register_driven_output;
	ssc_osc_e osc_select;
	int errors, tests_run, cycles, i, n;
	logic [7:0] ra [7];

	ssc_sideband_control u_ssc_sideband_control (.clk(clk), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .pclk(pclk), .power_down(power_down), .chan_b_strap(strap),
		.remote_interrupt_in_n(remote_interrupt_in_n), .interrupt_out_n(interrupt_out_n),
		.color_low_in(color_low_in), .color_low_out(color_low_out),
		.color_low_oe(color_low_oe), .bc_gpio(bc_gpio), .fwd_gpio(fwd_gpio),
		.register_driven_output(register_driven_output), .aud_clk(aud_clk), .aud_ws(aud_ws),
		.aud_da(aud_da), .secondary_audio_data(aud_db), .video_de(video_de),
		.fwd_aud(fwd_aud), .fwd_aud_valid(fwd_aud_valid), .frame_strobe(frame_strobe),
		.pattern_active(pattern_active), .zero_payload(zero_payload),
		.link_enable(link_enable), .use_oscillator(use_oscillator), .osc_select(osc_select),
		.selftest_req(selftest_req), .link_detect(link_detect), .bc_crc_err(bc_crc_err));
	ssc_deser_model u_ssc_deser_model (.clk(clk), .reset(reset), .frame_strobe(frame_strobe),
		.bist_cmd(bist_cmd), .err_cmd(err_cmd), .int_cmd(int_cmd), .bc_level(bc_level),
		.bc_gpio(bc_gpio), .selftest_req(selftest_req), .link_detect(link_detect),
		.bc_crc_err(bc_crc_err), .remote_interrupt_in_n(remote_interrupt_in_n),
		.pass_out(pass_out));

	// system clock, 50 ns period
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// pixel clock, 400 ns; toggles on falling clk edges so sampling never races
	initial begin
		pclk = 1'b0;
		forever #200 if (pclk_on) pclk = ~pclk;
	end
	// hang guard: the sequence needs well under this many cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			conclude();
		end
	end

	task automatic chk(input logic [15:0] s, input logic [15:0] e, input string m);
		tests_run++;
		if (s !== e) begin
			errors++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, s, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// data stands only in the cycle after the strobe is taken
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic wait_int(input logic v);
		for (n = 0; n < 30 && interrupt_out_n !== v; n++) @(posedge clk);
		#1;
	endtask

	task t_regs;
		ra = '{ADDR_GPIO0, ADDR_GPIO21, ADDR_GPO4_IO3, ADDR_GPO65, ADDR_GPO87, ADDR_DPATH,
			ADDR_INTCTL};
		chk(interrupt_out_n, 1'b1, "int idle");
		rd(ADDR_SBCTL, d);
		chk(d, RST_SBCTL, "sbctl rst");
		for (i = 0; i < 7; i++) begin
			rd(ra[i], d);
			chk(d, RST_CFG, "cfg rst");
			wr(ra[i], 8'hA5);
			rd(ra[i], d);
			chk(d, 8'hA5, "cfg rw");
			@(posedge clk);
			#1 chk(reg_rdata, 8'h00, "rdata one cycle");
			wr(ra[i], 8'h00);
		end
		wr(ADDR_CRCCNT, 8'h5A);
		rd(ADDR_CRCCNT, d);
		chk(d, 8'h00, "ro write");
		rd(8'h40, d);
		chk(d, 8'h00, "unmapped");
		$display("test regs done");
	endtask

	task t_int;
		wr(ADDR_INTCTL, 8'h01);
		int_cmd <= 1'b1;
		repeat (30) @(posedge clk);
		#1 chk(interrupt_out_n, 1'b1, "int masked");
		rd(ADDR_ISR, d);
		int_cmd <= 1'b0;
		wr(ADDR_INTCTL, 8'h21);
		repeat (10) @(posedge clk);
		int_cmd <= 1'b1;
		wait_int(1'b0);
		chk(interrupt_out_n, 1'b0, "int low");
		rd(ADDR_ISR, d);
		chk(d[0], 1'b1, "isr pending");
		repeat (2) @(posedge clk);
		#1 chk(interrupt_out_n, 1'b1, "int released");
		repeat (30) @(posedge clk);
		#1 chk(interrupt_out_n, 1'b1, "no re-raise");
		rd(ADDR_ISR, d);
		chk(d[0], 1'b0, "isr clear");
		int_cmd <= 1'b0;
		repeat (10) @(posedge clk);
		int_cmd <= 1'b1;
		wait_int(1'b0);
		chk(interrupt_out_n, 1'b0, "new fall");
		rd(ADDR_ISR, d);
		int_cmd <= 1'b0;
		$display("test int done");
	endtask

	task t_gpo;
		wr(ADDR_GPO87, 8'h99);
		wr(ADDR_GPO65, 8'h99);
		wr(ADDR_GPO4_IO3, 8'h90);
		repeat (3) @(posedge clk);
		#1 chk(register_driven_output, 5'h1F, "gpo ones");
		chk(color_low_oe, 4'h0, "gpo only");
		wr(ADDR_GPO87, 8'h19);
		wr(ADDR_GPO65, 8'h91);
		wr(ADDR_GPO4_IO3, 8'h10);
		wr(ADDR_GPO87, 8'h00);
		repeat (3) @(posedge clk);
		#1 chk(register_driven_output, 5'b01100, "gpo mix");
		wr(ADDR_GPO87, 8'h91);
		repeat (3) @(posedge clk);
		#1 chk(register_driven_output, 5'b10100, "gpo 8 one 7 zero");
		$display("test gpo done");
	endtask

	task t_gpio;
		wr(ADDR_DPATH, 8'h04);
		wr(ADDR_GPO4_IO3, 8'h03);
		wr(ADDR_GPIO21, 8'h53);
		wr(ADDR_GPIO0, 8'h95);
		bc_level <= 4'hF;
		color_low_in <= 4'b1010;
		repeat (40) @(posedge clk);
		#1 chk(color_low_oe, 4'b0101, "oe");
		chk(color_low_out, 4'b0101, "bc out");
		chk(fwd_gpio, 4'b1010, "fwd in");
		bc_level <= 4'h0;
		color_low_in <= 4'b0111;
		wr(ADDR_GPIO0, 8'h93);
		repeat (40) @(posedge clk);
		#1 chk(color_low_out[2], 1'b0, "bc low");
		chk(fwd_gpio, 4'b0011, "fwd mix");
		wr(ADDR_DPATH, 8'h00);
		repeat (40) @(posedge clk);
		#1 chk(color_low_oe, 4'h0, "24b oe");
		chk(fwd_gpio, 4'h0, "24b fwd");
		$display("test gpio done");
	endtask

	task t_audio;
		aud_clk <= 1'b1;
		aud_da <= 1'b1;
		aud_db <= 1'b1;
		video_de <= 1'b1;
		repeat (40) @(posedge clk);
		#1 chk(fwd_aud, 4'b0101, "aud 3");
		chk(fwd_aud_valid, 1'b1, "aud active");
		wr(ADDR_DPATH, 8'h01);
		repeat (40) @(posedge clk);
		#1 chk(fwd_aud, 4'b1101, "aud chb");
		wr(ADDR_SBCTL, 8'h30);
		repeat (40) @(posedge clk);
		#1 chk(fwd_aud_valid, 1'b0, "blank only");
		video_de <= 1'b0;
		repeat (40) @(posedge clk);
		#1 chk(fwd_aud_valid, 1'b1, "in blank");
		wr(ADDR_SBCTL, 8'h10);
		wr(ADDR_DPATH, 8'h04);
		wr(ADDR_GPIO21, 8'h33);
		$display("test audio done");
	endtask

	// second reset in mid-run with the channel B strap tied high
	task t_strap;
		strap <= 1'b1;
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		#1 chk(interrupt_out_n, 1'b1, "int after reset");
		repeat (20) @(posedge clk);
		rd(ADDR_STAT, d);
		chk(d[2], 1'b1, "strap seen");
		rd(ADDR_DPATH, d);
		chk(d, RST_CFG, "dpath cleared");
		chk(fwd_aud, 4'b1101, "strap chb");
		strap <= 1'b0;
		$display("test strap done");
	endtask

	task t_bist;
		wr(ADDR_SBCTL, 8'h18);
		bist_cmd <= 1'b1;
		repeat (20) @(posedge clk);
		#1 chk(pattern_active, 1'b0, "compat");
		rd(ADDR_STAT, d);
		chk(d[0], 1'b0, "compat stat");
		wr(ADDR_SBCTL, 8'h10);
		repeat (40) @(posedge clk);
		#1 chk({pattern_active, zero_payload, link_enable}, 3'b111, "bist run");
		chk(fwd_gpio, 4'h0, "inputs ignored");
		err_cmd <= 1'b1;
		for (i = 0, n = 0; i < 3 && n < 200; n++) begin
			@(posedge clk);
			#1 if (bc_crc_err) i++;
		end
		err_cmd <= 1'b0;
		repeat (4) @(posedge clk);
		rd(ADDR_CRCCNT, d);
		chk(d, 8'h03, "crc count");
		bist_cmd <= 1'b0;
		repeat (10) @(posedge clk);
		#1 chk(pattern_active, 1'b0, "bist off");
		chk(pass_out, 1'b0, "pass held");
		rd(ADDR_CRCCNT, d);
		chk(d, 8'h03, "crc kept");
		bist_cmd <= 1'b1;
		repeat (5) @(posedge clk);
		rd(ADDR_CRCCNT, d);
		chk(d, 8'h00, "crc cleared");
		bist_cmd <= 1'b0;
		repeat (10) @(posedge clk);
		$display("test bist done");
	endtask

	task t_pattern;
		wr(ADDR_SBCTL, 8'h11);
		repeat (10) @(posedge clk);
		#1 chk(pattern_active, 1'b1, "pattern");
		chk(osc_select, OSC_33, "osc 33");
		power_down <= 1'b1;
		repeat (10) @(posedge clk);
		#1 chk(pattern_active, 1'b0, "powered down");
		chk(link_enable, 1'b0, "link off");
		power_down <= 1'b0;
		pclk_on = 1'b0;
		wr(ADDR_SBCTL, 8'h51);
		repeat (40) @(posedge clk);
		#1 chk(use_oscillator, 1'b1, "osc fallback");
		for (i = 0, n = 0; i < 20; i++) begin
			@(posedge clk);
			#1 if (frame_strobe) n++;
		end
		chk(n >= 5, 1'b1, "osc frames");
		wr(ADDR_SBCTL, 8'h53);
		repeat (3) @(posedge clk);
		#1 chk(osc_select, OSC_25, "osc 25");
		wr(ADDR_SBCTL, 8'h55);
		repeat (3) @(posedge clk);
		#1 chk(osc_select, OSC_12P5, "osc lf");
		pclk_on = 1'b1;
		wr(ADDR_SBCTL, 8'h10);
		repeat (40) @(posedge clk);
		#1 chk(use_oscillator, 1'b0, "pclk back");
		$display("test pattern done");
	endtask

	task conclude;
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// main sequence
	initial begin
		{reset, reg_wr, reg_rd, power_down, video_de, strap} = 6'b100000;
		{reg_addr, reg_wdata} = 16'h0000;
		{bist_cmd, err_cmd, int_cmd, aud_clk, aud_ws, aud_da, aud_db} = 7'h00;
		{color_low_in, bc_level} = 8'h00;
		pclk_on = 1'b1;
		errors = 0;
		tests_run = 0;
		cycles = 0;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		t_regs();
		t_int();
		t_gpo();
		t_gpio();
		t_audio();
		t_strap();
		t_bist();
		t_pattern();
		conclude();
	end
endmodule // ssc_sideband_control_test
